/* File: logic/chan_div.sv */
// Cascaded two-stage output channel divider with its register file.
// Assumes i_clk is the distribution clock and i_sync comes from a pin.
`timescale 1ns/1ps

module chan_div (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [chan_div_pkg::ADDR_W-1:0] i_addr,
	input wire logic [chan_div_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [chan_div_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_sync,
	output logic o_chan_level,
	output logic o_chan_tick,
	output logic o_duty_fix_en
);

	// ************************************************************
	// Register file.
	// ************************************************************
	chan_div_pkg::bus_req_t req;
	logic [chan_div_pkg::DATA_W-1:0] first_counts_reg;
	logic [chan_div_pkg::DATA_W-1:0] phase_reg;
	logic [chan_div_pkg::DATA_W-1:0] second_counts_reg;
	logic [chan_div_pkg::DATA_W-1:0] control_reg;
	logic [chan_div_pkg::DATA_W-1:0] duty_reg;
	logic [chan_div_pkg::DATA_W-1:0] rdata_next;

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			first_counts_reg <= chan_div_pkg::RESET_VALUE;
			phase_reg <= chan_div_pkg::RESET_VALUE;
			second_counts_reg <= chan_div_pkg::RESET_VALUE;
			control_reg <= chan_div_pkg::RESET_VALUE;
			duty_reg <= chan_div_pkg::RESET_VALUE;
		end else if (req.wr) begin
			unique case (req.addr)
				chan_div_pkg::OFS_FIRST_COUNTS: first_counts_reg <= req.wdata;
				chan_div_pkg::OFS_PHASE: phase_reg <= req.wdata;
				chan_div_pkg::OFS_SECOND_COUNTS: second_counts_reg <= req.wdata;
				chan_div_pkg::OFS_CONTROL: control_reg <= req.wdata & chan_div_pkg::CONTROL_MASK;
				chan_div_pkg::OFS_DUTY: duty_reg <= req.wdata & chan_div_pkg::DUTY_MASK;
				default: ;
			endcase
		end
	end

	always_comb begin
		rdata_next = 8'h00;
		unique case (req.addr)
			chan_div_pkg::OFS_FIRST_COUNTS: rdata_next = first_counts_reg;
			chan_div_pkg::OFS_PHASE: rdata_next = phase_reg;
			chan_div_pkg::OFS_SECOND_COUNTS: rdata_next = second_counts_reg;
			chan_div_pkg::OFS_CONTROL: rdata_next = control_reg;
			chan_div_pkg::OFS_DUTY: rdata_next = duty_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// Read data stand for exactly the one cycle after the strobe.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (req.rd) begin
			o_rdata <= rdata_next;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// The corrector itself sits in the analog output path; this only steers it.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_duty_fix_en <= 1'b1;
		end else begin
			o_duty_fix_en <= ~duty_reg[chan_div_pkg::BIT_DUTY_FIX_DISABLE];
		end
	end

	// ************************************************************
	// Stage settings.
	// ************************************************************
	chan_div_pkg::stage_cfg_t cfg [chan_div_pkg::NUM_STAGES];
	logic nosync;
	logic force_high;

	assign cfg[0] = '{
		low_cnt: first_counts_reg[chan_div_pkg::LOW_LSB +: chan_div_pkg::CNT_W],
		high_cnt: first_counts_reg[chan_div_pkg::HIGH_LSB +: chan_div_pkg::CNT_W],
		phase: phase_reg[chan_div_pkg::PHASE1_LSB +: chan_div_pkg::CNT_W],
		start_high: control_reg[chan_div_pkg::BIT_START1],
		bypass: control_reg[chan_div_pkg::BIT_BYPASS1]
	};
	assign cfg[1] = '{
		low_cnt: second_counts_reg[chan_div_pkg::LOW_LSB +: chan_div_pkg::CNT_W],
		high_cnt: second_counts_reg[chan_div_pkg::HIGH_LSB +: chan_div_pkg::CNT_W],
		phase: phase_reg[chan_div_pkg::PHASE2_LSB +: chan_div_pkg::CNT_W],
		start_high: control_reg[chan_div_pkg::BIT_START2],
		bypass: control_reg[chan_div_pkg::BIT_BYPASS2]
	};
	assign nosync = control_reg[chan_div_pkg::BIT_NOSYNC];
	assign force_high = control_reg[chan_div_pkg::BIT_FORCE];

	// ************************************************************
	// Synchronisation strobe.
	// ************************************************************
	logic sync_meta_reg;
	logic sync_safe_reg;
	logic sync_prev_reg;
	logic restart;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync_meta_reg <= 1'b0;
			sync_safe_reg <= 1'b0;
			sync_prev_reg <= 1'b0;
		end else begin
			sync_meta_reg <= i_sync;
			sync_safe_reg <= sync_meta_reg;
			sync_prev_reg <= sync_safe_reg;
		end
	end

	// Restart on the rising edge of the strobe unless the channel ignores it.
	assign restart = sync_safe_reg & ~sync_prev_reg & ~nosync;

	// ************************************************************
	// Divider stages.
	// ************************************************************
	chan_div_pkg::stage_state_t state_reg [chan_div_pkg::NUM_STAGES];
	logic [chan_div_pkg::CNT_W-1:0] cnt_reg [chan_div_pkg::NUM_STAGES];
	logic level_reg [chan_div_pkg::NUM_STAGES];
	logic tick_in [chan_div_pkg::NUM_STAGES];
	logic rise [chan_div_pkg::NUM_STAGES];
	logic stage_level [chan_div_pkg::NUM_STAGES];

	// The first stage sees every distribution clock cycle.
	assign tick_in[0] = 1'b1;
	// The second stage is clocked by rising edges of the first stage.
	assign tick_in[1] = rise[0];

	function automatic logic [chan_div_pkg::CNT_W-1:0] limit_of(input chan_div_pkg::stage_cfg_t c, input logic lvl);
		limit_of = lvl ? c.high_cnt : c.low_cnt;
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < chan_div_pkg::NUM_STAGES; gi++) begin : g_stage
			logic at_limit;
			assign at_limit = (cnt_reg[gi] == limit_of(cfg[gi], level_reg[gi]));

			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					state_reg[gi] <= chan_div_pkg::ST_RUN;
					cnt_reg[gi] <= 4'h0;
					level_reg[gi] <= 1'b0;
				end else if (cfg[gi].bypass) begin
					// Powered down: the counter is parked in its reset state.
					state_reg[gi] <= chan_div_pkg::ST_RUN;
					cnt_reg[gi] <= 4'h0;
					level_reg[gi] <= 1'b0;
				end else if (restart) begin
					state_reg[gi] <= chan_div_pkg::ST_DELAY;
					cnt_reg[gi] <= cfg[gi].phase;
					level_reg[gi] <= cfg[gi].start_high;
				end else if (tick_in[gi]) begin
					unique case (state_reg[gi])
						chan_div_pkg::ST_DELAY: begin
							if (cnt_reg[gi] == 4'h0) begin
								state_reg[gi] <= chan_div_pkg::ST_RUN;
							end else begin
								cnt_reg[gi] <= cnt_reg[gi] - 4'h1;
							end
						end
						chan_div_pkg::ST_RUN: begin
							if (at_limit) begin
								cnt_reg[gi] <= 4'h0;
								level_reg[gi] <= ~level_reg[gi];
							end else begin
								cnt_reg[gi] <= cnt_reg[gi] + 4'h1;
							end
						end
						default: begin
							state_reg[gi] <= chan_div_pkg::ST_RUN;
							cnt_reg[gi] <= 4'h0;
						end
					endcase
				end
			end

			// A bypassed stage passes each input cycle straight through.
			assign rise[gi] = cfg[gi].bypass ? tick_in[gi] :
				(~restart & tick_in[gi] & (state_reg[gi] == chan_div_pkg::ST_RUN) & at_limit & ~level_reg[gi]);
		end
	endgenerate

	// A bypassed first stage is the raw clock, which shows here as a steady high.
	assign stage_level[0] = cfg[0].bypass ? 1'b1 : level_reg[0];
	assign stage_level[1] = cfg[1].bypass ? stage_level[0] : level_reg[1];

	// ************************************************************
	// Channel output.
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_chan_level <= 1'b0;
			o_chan_tick <= 1'b0;
		end else if (nosync && force_high) begin
			o_chan_level <= 1'b1;
			o_chan_tick <= 1'b0;
		end else begin
			o_chan_level <= stage_level[1];
			o_chan_tick <= rise[1];
		end
	end

	// ************************************************************
	// Checks.
	// ************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_stage2_run_tick;
		!cfg[1].bypass && !restart && tick_in[1] && state_reg[1] == chan_div_pkg::ST_RUN;
	endsequence

	sequence s_obeyed_sync;
		sync_safe_reg && !sync_prev_reg && !nosync;
	endsequence

	sequence s_stage1_run;
		!cfg[0].bypass && !restart && state_reg[0] == chan_div_pkg::ST_RUN;
	endsequence

	a_low_span_end: assert property (
		s_stage2_run_tick and (!level_reg[1] && cnt_reg[1] == cfg[1].low_cnt) |=> level_reg[1] && cnt_reg[1] == 4'h0
	) else $error("second stage did not leave low after low count plus one");

	a_high_span_end: assert property (
		s_stage2_run_tick and (level_reg[1] && cnt_reg[1] == cfg[1].high_cnt) |=> !level_reg[1] && cnt_reg[1] == 4'h0
	) else $error("second stage did not leave high after high count plus one");

	a_first_stage_span: assert property (
		(!cfg[0].bypass && !restart && state_reg[0] == chan_div_pkg::ST_RUN && cnt_reg[0] != limit_of(cfg[0], level_reg[0]))
		|=> $stable(level_reg[0])
	) else $error("first stage toggled before its count ended");

	a_phase_load: assert property (
		(s_obeyed_sync and !cfg[0].bypass) |=> state_reg[0] == chan_div_pkg::ST_DELAY && cnt_reg[0] == $past(cfg[0].phase)
	) else $error("first stage did not load its phase offset on sync");

	a_bypass_two: assert property (
		cfg[1].bypass |-> rise[1] == rise[0] && stage_level[1] == stage_level[0]
	) else $error("bypassed second stage does not pass its input");

	a_bypass_one: assert property (
		cfg[0].bypass |-> rise[0] && stage_level[0]
	) else $error("bypassed first stage does not pass the clock");

	a_nosync_ignore: assert property (
		nosync |-> !restart
	) else $error("sync acted while ignored");

	a_force_static: assert property (
		(nosync && force_high) ##1 (nosync && force_high) |-> o_chan_level && !o_chan_tick
	) else $error("forced high output not static high");

	// Bypass is taken from the restart edge, so a control write on the next edge is not flagged.
	a_start_level: assert property (
		s_obeyed_sync |=> ($past(cfg[1].bypass) || level_reg[1] == $past(cfg[1].start_high))
			&& ($past(cfg[0].bypass) || level_reg[0] == $past(cfg[0].start_high))
	) else $error("stage did not restart at its start level");

	a_duty_follow: assert property (
		$changed(duty_reg[chan_div_pkg::BIT_DUTY_FIX_DISABLE]) |=> o_duty_fix_en == !$past(duty_reg[chan_div_pkg::BIT_DUTY_FIX_DISABLE])
	) else $error("duty correction enable does not follow its register");

	a_chain_clock: assert property (
		(!cfg[1].bypass && !rise[0] && !restart) |=> $stable(cnt_reg[1]) && $stable(level_reg[1])
	) else $error("second stage advanced without a first stage edge");

	a_read_one_cycle: assert property (
		!req.rd |=> o_rdata == 8'h00
	) else $error("read data stood outside the answer cycle");

	a_first_toggle: assert property (
		s_stage1_run and (cnt_reg[0] == limit_of(cfg[0], level_reg[0]))
		|=> level_reg[0] != $past(level_reg[0]) && cnt_reg[0] == 4'h0
	) else $error("first stage did not toggle when its count ended");

	a_phase_second: assert property (
		(s_obeyed_sync and !cfg[1].bypass) |=> state_reg[1] == chan_div_pkg::ST_DELAY && cnt_reg[1] == $past(cfg[1].phase)
	) else $error("second stage did not load its phase offset on sync");

	a_delay_step: assert property (
		(!cfg[1].bypass && !restart && tick_in[1] && state_reg[1] == chan_div_pkg::ST_DELAY && cnt_reg[1] != 4'h0)
		|=> cnt_reg[1] == $past(cnt_reg[1]) - 4'h1
	) else $error("second stage phase delay did not count down");

	a_delay_exit: assert property (
		(!cfg[0].bypass && !restart && state_reg[0] == chan_div_pkg::ST_DELAY && cnt_reg[0] == 4'h0)
		|=> state_reg[0] == chan_div_pkg::ST_RUN && $stable(level_reg[0])
	) else $error("first stage did not leave its phase delay in time");

	a_tick_follows: assert property (
		(rise[1] && !(nosync && force_high)) |=> o_chan_tick
	) else $error("channel tick missing after a second stage rise");

	a_control_mask: assert property (
		(req.wr && req.addr == chan_div_pkg::OFS_CONTROL) |=> control_reg == ($past(req.wdata) & chan_div_pkg::CONTROL_MASK)
	) else $error("control register did not take the masked write");

	a_read_back: assert property (
		(req.rd && req.addr == chan_div_pkg::OFS_PHASE) |=> o_rdata == $past(phase_reg)
	) else $error("read data do not show the addressed register");

	a_level_follow: assert property (
		!(nosync && force_high) |=> o_chan_level == $past(stage_level[1])
	) else $error("channel output does not follow the second stage");

	a_bypass_park: assert property (
		cfg[0].bypass |=> cnt_reg[0] == 4'h0 && !level_reg[0] && state_reg[0] == chan_div_pkg::ST_RUN
	) else $error("bypassed first stage is not parked");

	a_nosync_state: assert property (
		(nosync && sync_safe_reg && !sync_prev_reg && !cfg[0].bypass && state_reg[0] == chan_div_pkg::ST_RUN)
		|=> state_reg[0] == chan_div_pkg::ST_RUN
	) else $error("first stage entered its phase delay on an ignored sync");

endmodule // chan_div

/* File: shared/chan_div_pkg.sv */
// Package for the cascaded channel divider: register map, field layout,
// reset values and carrier types.
// Assumes one clock that stands for the distribution clock tree input.
package chan_div_pkg;

	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int CNT_W = 4;
	localparam int NUM_STAGES = 2;

	// ************************************************************
	// Register offsets.
	// ************************************************************
	localparam logic [ADDR_W-1:0] OFS_FIRST_COUNTS = 9'h19e;
	localparam logic [ADDR_W-1:0] OFS_PHASE = 9'h19f;
	localparam logic [ADDR_W-1:0] OFS_SECOND_COUNTS = 9'h1a0;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 9'h1a1;
	localparam logic [ADDR_W-1:0] OFS_DUTY = 9'h1a2;

	// ************************************************************
	// Field positions and reset values.
	// ************************************************************
	localparam int LOW_LSB = 4;
	localparam int HIGH_LSB = 0;
	localparam int PHASE2_LSB = 4;
	localparam int PHASE1_LSB = 0;
	localparam int BIT_BYPASS2 = 5;
	localparam int BIT_BYPASS1 = 4;
	localparam int BIT_NOSYNC = 3;
	localparam int BIT_FORCE = 2;
	localparam int BIT_START2 = 1;
	localparam int BIT_START1 = 0;
	localparam int BIT_DUTY_FIX_DISABLE = 0;
	localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;
	localparam logic [DATA_W-1:0] CONTROL_MASK = 8'h3f;
	localparam logic [DATA_W-1:0] DUTY_MASK = 8'h01;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_DELAY = 2'b10
	} stage_state_t;

	// Settings of one divider stage.
	typedef struct packed {
		logic [CNT_W-1:0] low_cnt;
		logic [CNT_W-1:0] high_cnt;
		logic [CNT_W-1:0] phase;
		logic start_high;
		logic bypass;
	} stage_cfg_t;

	// Register bus request.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

endpackage

/* File: tb/chan_div_tb.sv */
// Self-checking bench for the cascaded channel divider.
// Assumes the block sits alone on one 50 MHz clock and the bench plays the register master.
`timescale 1ns/1ps

module chan_div_tb;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [chan_div_pkg::ADDR_W-1:0] i_addr = 9'h000;
	logic [chan_div_pkg::DATA_W-1:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_sync = 1'b0;
	logic [chan_div_pkg::DATA_W-1:0] o_rdata;
	logic o_chan_level;
	logic o_chan_tick;
	logic o_duty_fix_en;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [15:0] h;
	logic [15:0] l;
	logic [15:0] h0;
	logic [15:0] t;
	logic [7:0] v;
	// Divider table: first counts, second counts, control, expected high and low run.
	localparam logic [7:0] FC[7] = '{8'h00, 8'h00, 8'h00, 8'h42, 8'h11, 8'h00, 8'h00};
	localparam logic [7:0] SC[7] = '{8'h00, 8'h35, 8'hf0, 8'h00, 8'h00, 8'h21, 8'h35};
	localparam logic [7:0] CT[7] = '{8'h10, 8'h10, 8'h10, 8'h20, 8'h00, 8'h00, 8'h14};
	localparam logic [15:0] EH[7] = '{16'h1, 16'h6, 16'h1, 16'h3, 16'h4, 16'h4, 16'h6};
	localparam logic [15:0] EL[7] = '{16'h1, 16'h4, 16'h10, 16'h5, 16'h4, 16'h6, 16'h4};
	localparam logic [8:0] RA[6] = '{9'h19e, 9'h19f, 9'h1a0, 9'h1a1, 9'h1a2, 9'h1a3};
	localparam logic [7:0] RV[6] = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h01, 8'h00};

	chan_div uut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_sync(i_sync),
		.o_chan_level(o_chan_level),
		.o_chan_tick(o_chan_tick),
		.o_duty_fix_en(o_duty_fix_en)
	);

	always #10 i_clk = ~i_clk;

	// ************************************************************
	// Tasks.
	// ************************************************************
	task automatic end_of_test();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// A hung wait would otherwise stall the run forever.
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc();
		@(posedge i_clk);
		#1;
	endtask

	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask

	task automatic wait_lvl(input logic lv);
		int n;
		n = 0;
		while (o_chan_level !== lv && n < 600) begin
			cyc();
			n++;
		end
	endtask

	// Counts one full high run and the low run that follows it.
	task automatic meas(output logic [15:0] hc, output logic [15:0] lc, output logic [15:0] tc);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		hc = 0;
		tc = 0;
		while (o_chan_level === 1'b1 && hc < 600) begin
			cyc();
			hc++;
			tc = tc + 16'(o_chan_tick);
		end
		lc = 0;
		while (o_chan_level === 1'b0 && lc < 600) begin
			cyc();
			lc++;
			tc = tc + 16'(o_chan_tick);
		end
	endtask

	task automatic pulse_sync();
		@(posedge i_clk);
		i_sync <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_sync <= 1'b0;
		#1;
	endtask

	// Syncs at the start of a low run and returns the following high run.
	task automatic sync_run(input logic [7:0] ctl, input logic [7:0] ph, output logic [15:0] hc);
		wr(9'h1a1, ctl);
		wr(9'h19f, ph);
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		pulse_sync();
		hc = 0;
		while (o_chan_level !== 1'b1 && hc < 8) begin
			cyc();
			hc++;
		end
		chk(16'(hc < 8), 16'h1);
		hc = 0;
		while (o_chan_level === 1'b1 && hc < 600) begin
			cyc();
			hc++;
		end
	endtask

	// ************************************************************
	// Main sequence.
	// ************************************************************
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		cyc();
		chk(16'(o_duty_fix_en), 16'h1);
		for (int i = 0; i < 6; i++) begin
			rd(RA[i], v);
			chk(16'(v), 16'h0);
			wr(RA[i], 8'hff);
			rd(RA[i], v);
			chk(16'(v), 16'(RV[i]));
		end
		cyc();
		chk(16'(o_duty_fix_en), 16'h0);
		for (int i = 0; i < 5; i++) begin
			wr(RA[i], 8'h00);
		end
		cyc();
		chk(16'(o_duty_fix_en), 16'h1);
		for (int i = 0; i < 7; i++) begin
			wr(9'h19e, FC[i]);
			wr(9'h1a0, SC[i]);
			wr(9'h1a1, CT[i]);
			meas(h, l, t);
			meas(h, l, t);
			chk(h, EH[i]);
			chk(l, EL[i]);
			chk(t, 16'h1);
		end
		// Static high needs both the force and the ignore bits.
		wr(9'h1a1, 8'h0c);
		repeat (4) cyc();
		h = 0;
		t = 0;
		for (int i = 0; i < 20; i++) begin
			cyc();
			h = h + 16'(o_chan_level);
			t = t + 16'(o_chan_tick);
		end
		chk(h, 16'h14);
		chk(t, 16'h0);
		// Phase offset adds its value in input cycles to the first run after sync.
		wr(9'h1a0, 8'hff);
		wr(9'h19e, 8'hff);
		sync_run(8'h12, 8'h00, h0);
		sync_run(8'h12, 8'h80, h);
		chk(h - h0, 16'h8);
		sync_run(8'h21, 8'h00, h0);
		sync_run(8'h21, 8'h08, h);
		chk(h - h0, 16'h8);
		// A start-low restart cuts the high run short after one more sample.
		wr(9'h1a1, 8'h10);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		pulse_sync();
		h = 0;
		for (int i = 0; i < 10; i++) begin
			cyc();
			h = h + 16'(o_chan_level);
		end
		chk(h, 16'h1);
		// With sync ignored the low run is left alone.
		wr(9'h1a1, 8'h1a);
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		pulse_sync();
		h = 0;
		for (int i = 0; i < 10; i++) begin
			cyc();
			h = h + 16'(o_chan_level);
		end
		chk(h, 16'h0);
		end_of_test();
	end
endmodule // chan_div_tb
